// ==== hw/smbus_charger.sv ====
// SMBus command logic and charge-mode control of a smart charger.
// Assumes open-drain bus pins resolved outside, slow analog status
// levels on pins, and a free-running oversampling link clock.
//
// What this block does
// - Alert on flag_a, presence, alarm, power-on
// - Current command 0x14 is a word write
// - Delivered current never exceeds resistor limit
// - Truncate current and voltage to DAC steps
// - Reduce current when battery voltage too high
// - Flag current above limit per setting
// - Voltage command 0x15 is a word write
// - Voltage 0x0001..0x049F behaves as zero
// - Delivered voltage never exceeds resistor limit
// - Reduce voltage when battery current too high
// - Flag voltage above limit per setting
// - Critical alarm bits inhibit charging, set block
// - Other alarm bits cause no action
// - Vendor write keeps only pulse disable bit
// - Pulsed mode below sixteenth in controlled charging unless disabled
// - Vendor read returns bit and version
// - Answer alert address only while alerting
// - Commands from battery or host alike
// - Wake charging entry conditions
// - Wake charging timeout on cold or underrange line, unsafe line exit
// - Both commands written enter controlled charging
// - Clear alarm block on rewrite, power, removal
`timescale 1ns/100ps
module smbus_charger #(
  parameter int          TIMEOUT_MS = 1000,
  parameter logic [11:0] VERSION_ID = 12'h5A1 // Value is arbitrary
) (
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  input  wire logic                  clock_enable,
  input  wire logic                  link_clk,
  input  wire logic                  scl,
  input  wire logic                  sda_in,
  output logic                       sda_out,
  output logic                       sda_oe_n,
  input  wire logic                  alert_in,
  output logic                       alert_out,
  output logic                       alert_oe_n,
  input  wire logic                  flag_a,
  input  wire logic                  battery_present_flag,
  input  wire charger_pkg::safety_t  safety,
  input  wire logic [1:0]            current_limit_resistor,
  input  wire logic [2:0]            voltage_limit_resistor,
  input  wire logic                  battery_over_voltage,
  input  wire logic                  battery_over_current,
  output charger_pkg::setpoint_t     setpoint,
  output charger_pkg::status_t       status
);
  import charger_pkg::*;

  localparam int TIMEOUT_CYCLES = TIMEOUT_MS * (CLOCK_HZ / 1000);

  // ==========================================================
  // Link-side state
  typedef struct packed {
    link_state_t st;
    link_state_t after;
    logic [3:0]  bits;
    logic [7:0]  sh;
    logic [7:0]  cmd;
    logic [7:0]  dlo;
    logic [7:0]  tx;
    logic [7:0]  tx_hi;
    logic [15:0] word;
    logic        tx_more;
    logic        ara;
    logic        drive;
    logic        scl_d;
    logic        sda_d;
    logic        wr_tog;
    logic        ara_tog;
  } link_t;

  // ==========================================================
  // System-side state
  typedef struct packed {
    logic [15:0] cur_req;
    logic [15:0] volt_req;
    logic [31:0] timer;
    logic        flag_d;
    logic        pres_d;
    logic        wr_d;
    logic        ara_d;
    logic        alert;
    logic        alarm;
    logic        pmd;
    logic        cur_w;
    logic        volt_w;
    logic        rw_cur;
    logic        rw_volt;
    logic        fresh;
    logic        wake;
    logic        ctrl;
    setpoint_t   set;
    status_t     stat;
  } sys_t;

  link_t       l;
  link_t       next_l;
  sys_t        s;
  sys_t        next_s;
  logic [4:0]  lsync;
  logic [15:0] ssync;
  logic        scl_s;
  logic        sda_s;
  logic        l_ce;
  logic        alert_l;
  logic        pmd_l;
  logic [15:0] vendor_word;
  logic [15:0] cur_lim;
  logic [15:0] volt_lim;
  logic        cur_over;
  logic        volt_over;
  logic        low_band;

  // ==========================================================
  // Crossings into the link domain
  bit_sync #(.WIDTH(5)) u_link_sync (
    .clock (link_clk),
    .rst_n (rst_n),
    .d     ({scl, sda_in, clock_enable, s.alert, s.pmd}),
    .q     (lsync)
  );
  assign {scl_s, sda_s, l_ce, alert_l, pmd_l} = lsync;
  // Reserved top bits read as zero
  assign vendor_word = {3'b000, pmd_l, VERSION_ID};

  // ==========================================================
  // Bit-level slave: sample on SCL rise, drive on SCL fall
  always_comb begin
    next_l = l;
    if (l_ce) begin
      next_l.scl_d = scl_s;
      next_l.sda_d = sda_s;
      if (scl_s && l.scl_d && l.sda_d && !sda_s) begin
        // Start or repeated start restarts address reception
        next_l.st    = L_ADDR;
        next_l.bits  = 4'h0;
        next_l.drive = 1'b0;
      end else if (scl_s && l.scl_d && !l.sda_d && sda_s) begin
        next_l.st    = L_IDLE;
        next_l.drive = 1'b0;
      end else if (scl_s && !l.scl_d) begin
        if (l.st == L_ADDR || l.st == L_CMD ||
            l.st == L_DLO || l.st == L_DHI) begin
          next_l.sh   = {l.sh[6:0], sda_s};
          next_l.bits = 4'(l.bits + 4'h1);
        end else if (l.st == L_TX && !l.drive && !sda_s) begin
          // Lost priority arbitration: another sender pulled low
          next_l.st = L_WAIT;
        end else if (l.st == L_TXACK) begin
          if (!sda_s && l.tx_more) begin
            next_l.st      = L_TXNEXT;
            next_l.tx      = l.tx_hi;
            next_l.tx_more = 1'b0;
          end else begin
            next_l.st = L_WAIT;
          end
        end
      end else if (!scl_s && l.scl_d) begin
        if (l.bits == 4'h8 && (l.st == L_ADDR || l.st == L_CMD ||
            l.st == L_DLO || l.st == L_DHI)) begin
          next_l.bits  = 4'h0;
          next_l.drive = 1'b1;
          next_l.st    = L_ACK;
          unique case (l.st)
            L_ADDR: begin
              if (l.sh[7:1] == DEV_ADDR && !l.sh[0]) begin
                next_l.after = L_CMD;
              end else if (l.sh[7:1] == DEV_ADDR) begin
                // Write-only commands read back as released bus
                next_l.after   = L_TX;
                next_l.ara     = 1'b0;
                next_l.tx_more = 1'b1;
                next_l.tx      = (l.cmd == CMD_VENDOR) ?
                                 vendor_word[7:0] : 8'hFF;
                next_l.tx_hi   = (l.cmd == CMD_VENDOR) ?
                                 vendor_word[15:8] : 8'hFF;
              end else if (l.sh[7:1] == ARA_ADDR && l.sh[0] &&
                           alert_l) begin
                next_l.after   = L_TX;
                next_l.ara     = 1'b1;
                next_l.tx_more = 1'b0;
                next_l.tx      = ARA_REPLY;
              end else begin
                next_l.drive = 1'b0;
                next_l.st    = L_WAIT;
              end
            end
            L_CMD: begin
              next_l.cmd   = l.sh;
              next_l.after = L_DLO;
            end
            L_DLO: begin
              next_l.dlo   = l.sh;
              next_l.after = L_DHI;
            end
            L_DHI: begin
              // Word complete: hand it to the system domain
              next_l.word   = {l.sh, l.dlo};
              next_l.wr_tog = !l.wr_tog;
              next_l.after  = L_WAIT;
            end
          endcase
        end else if (l.st == L_ACK) begin
          next_l.st    = l.after;
          next_l.drive = (l.after == L_TX) ? !l.tx[7] : 1'b0;
        end else if (l.st == L_TX) begin
          if (l.bits == 4'h7) begin
            next_l.drive = 1'b0;
            next_l.st    = L_TXACK;
            next_l.bits  = 4'h0;
            // Whole address sent: alert may now be released
            if (l.ara) begin
              next_l.ara_tog = !l.ara_tog;
            end
          end else begin
            next_l.tx    = {l.tx[6:0], 1'b0};
            next_l.drive = !l.tx[6];
            next_l.bits  = 4'(l.bits + 4'h1);
          end
        end else if (l.st == L_TXNEXT) begin
          next_l.st    = L_TX;
          next_l.drive = !l.tx[7];
          next_l.bits  = 4'h0;
        end
      end
    end
  end

  // Link registers
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      l       <= '0;
      l.st    <= L_IDLE;
      l.after <= L_IDLE;
      l.scl_d <= 1'b1;
      l.sda_d <= 1'b1;
    end else begin
      l <= next_l;
    end
  end

  // ==========================================================
  // Crossings into the system domain
  bit_sync #(.WIDTH(16)) u_sys_sync (
    .clock (clock),
    .rst_n (rst_n),
    .d     ({flag_a, battery_present_flag, safety,
             current_limit_resistor, voltage_limit_resistor,
             battery_over_voltage, battery_over_current,
             l.wr_tog, l.ara_tog}),
    .q     (ssync)
  );

  value_limiter u_limiter (
    .cur_req  (s.cur_req),
    .volt_req (s.volt_req),
    .ilim_sel (ssync[8:7]),
    .vlim_sel (ssync[6:4]),
    .cur_lim  (cur_lim),
    .volt_lim (volt_lim),
    .cur_over (cur_over),
    .volt_over(volt_over),
    .low_band (low_band)
  );

  // ==========================================================
  // Command decode, alarm handling and charge modes
  always_comb begin
    logic    flag_s;
    logic    pres_s;
    safety_t line;
    logic    good;
    logic    wr_ev;
    logic    alarm_set;
    logic    charging;
    flag_s    = ssync[15];
    pres_s    = ssync[14];
    line      = ssync[13:9];
    good      = (line.cold || line.normal || line.underrange) &&
                !line.overrange && !line.hot;
    wr_ev     = ssync[1] ^ s.wr_d;
    // Only the critical bits count; the rest are dropped
    alarm_set = wr_ev && l.cmd == CMD_ALARM &&
                |(l.word & ALARM_STOP_MASK);
    charging  = 1'b0;
    next_s    = s;
    if (clock_enable) begin
      next_s.flag_d = flag_s;
      next_s.pres_d = pres_s;
      next_s.wr_d   = ssync[1];
      next_s.ara_d  = ssync[0];
      // Either master may write; no source check is made
      if (wr_ev) begin
        if (l.cmd == CMD_CURRENT) begin
          next_s.cur_req = l.word;
          next_s.cur_w   = 1'b1;
          next_s.rw_cur  = 1'b1;
        end else if (l.cmd == CMD_VOLTAGE) begin
          next_s.volt_req = l.word;
          next_s.volt_w   = 1'b1;
          next_s.rw_volt  = 1'b1;
        end else if (l.cmd == CMD_VENDOR) begin
          next_s.pmd = l.word[PMD_BIT];
        end
      end
      if (pres_s && !s.pres_d) begin
        next_s.fresh = 1'b1;
      end
      // Removal wipes requests and stops every mode
      if (!pres_s) begin
        next_s.cur_req  = 16'h0000;
        next_s.volt_req = 16'h0000;
        next_s.cur_w    = 1'b0;
        next_s.volt_w   = 1'b0;
        next_s.fresh    = 1'b0;
        next_s.wake     = 1'b0;
        next_s.ctrl     = 1'b0;
      end
      if ((next_s.rw_cur && next_s.rw_volt) || !flag_s || !pres_s)
      begin
        next_s.alarm = 1'b0;
      end
      // Set wins over clear in the same cycle
      if (alarm_set) begin
        next_s.alarm   = 1'b1;
        next_s.rw_cur  = 1'b0;
        next_s.rw_volt = 1'b0;
      end
      if (ssync[0] ^ s.ara_d) begin
        next_s.alert = 1'b0;
      end
      if (flag_s != s.flag_d || pres_s != s.pres_d ||
          (next_s.alarm && !s.alarm)) begin
        next_s.alert = 1'b1;
      end
      if (s.wake) begin
        next_s.timer = s.timer + 32'h0000_0001;
      end
      if (s.fresh && !(next_s.cur_w && next_s.volt_w) && good &&
          flag_s && !s.wake && !s.ctrl && pres_s) begin
        next_s.wake  = 1'b1;
        next_s.fresh = 1'b0;
        next_s.timer = 32'h0000_0000;
      end
      if (s.wake && (line.overrange || line.hot ||
          (s.timer >= 32'(TIMEOUT_CYCLES - 1) &&
           (line.cold || line.underrange)))) begin
        next_s.wake = 1'b0;
      end
      if (next_s.cur_w && next_s.volt_w && pres_s) begin
        next_s.wake  = 1'b0;
        next_s.ctrl  = 1'b1;
        next_s.fresh = 1'b0;
      end
      if (line.overrange || line.hot) begin
        next_s.ctrl = 1'b0;
      end
      // Alarm block and missing power gate all delivery
      charging = (next_s.wake || next_s.ctrl) && !next_s.alarm &&
                 flag_s && pres_s;
      next_s.set.current = !charging ? 16'h0000 :
                           next_s.wake ? WAKE_CURRENT : cur_lim;
      next_s.set.voltage = !charging ? 16'h0000 :
                           next_s.wake ? WAKE_VOLTAGE : volt_lim;
      next_s.stat.cur_or         = cur_over;
      next_s.stat.volt_or        = volt_over;
      next_s.stat.alarm_block    = next_s.alarm;
      next_s.stat.pulsed_low     = charging && !next_s.pmd &&
                                   !next_s.wake && low_band;
      next_s.stat.wake           = next_s.wake;
      next_s.stat.controlled     = next_s.ctrl;
      next_s.stat.charge_enable  = charging;
      next_s.stat.current_reduce = charging && ssync[3];
      next_s.stat.voltage_reduce = charging && ssync[2];
    end
  end

  // System registers; alert starts asserted for power-on
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s       <= '0;
      s.alert <= ALERT_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Pins and outputs
  assign sda_out    = 1'b0;
  assign sda_oe_n   = !l.drive;
  assign alert_out  = 1'b0;
  assign alert_oe_n = !s.alert;
  assign setpoint   = s.set;
  assign status     = s.stat;
endmodule

// ==== shared/charger_pkg.sv ====
// Shared constants and types of the smart charger command logic.
// Assumes one system clock at 20 MHz and an SMBus link clock domain.
package charger_pkg;
  // ==========================================================
  // Bus addresses and command codes
  localparam logic [6:0] DEV_ADDR    = 7'h09;
  localparam logic [6:0] ARA_ADDR    = 7'h0C;
  localparam logic [7:0] ARA_REPLY   = 8'h12;
  localparam logic [7:0] CMD_CURRENT = 8'h14;
  localparam logic [7:0] CMD_VOLTAGE = 8'h15;
  localparam logic [7:0] CMD_ALARM   = 8'h16;
  localparam logic [7:0] CMD_VENDOR  = 8'h3C;
  // ==========================================================
  // Field layouts
  localparam logic [15:0] ALARM_STOP_MASK = 16'hF000;
  localparam int          PMD_BIT         = 12;
  localparam logic [15:0] VOLT_ZERO_TOP   = 16'h049F;
  // ==========================================================
  // Limits per resistor setting, DAC steps and wake setpoints
  localparam logic [15:0] CUR_MAX [0:3] =
    '{16'h03FF, 16'h07FF, 16'h0BFF, 16'h0FFF};
  localparam logic [3:0]  CUR_SHIFT [0:3] =
    '{4'h0, 4'h1, 4'h2, 4'h2};
  localparam logic [15:0] VOLT_MAX [0:4] =
    '{16'h225F, 16'h332F, 16'h43FF, 16'h54CF, 16'h6D5F};
  localparam logic [3:0]  VOLT_SHIFT    = 4'h4;
  localparam logic [15:0] WAKE_CURRENT  = 16'h0080;
  localparam logic [15:0] WAKE_VOLTAGE  = 16'h2000;
  // ==========================================================
  // Timing and reset values
  localparam int          CLOCK_HZ      = 20_000_000;
  localparam logic        ALERT_RESET   = 1'b1;
  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    L_IDLE   = 4'b0000,
    L_ADDR   = 4'b0001,
    L_CMD    = 4'b0010,
    L_DLO    = 4'b0011,
    L_DHI    = 4'b0100,
    L_ACK    = 4'b0101,
    L_TX     = 4'b0110,
    L_TXACK  = 4'b0111,
    L_TXNEXT = 4'b1000,
    L_WAIT   = 4'b1001
  } link_state_t;
  typedef struct packed {
    logic cold;
    logic normal;
    logic underrange;
    logic overrange;
    logic hot;
  } safety_t;
  typedef struct packed {
    logic [15:0] current;
    logic [15:0] voltage;
  } setpoint_t;
  typedef struct packed {
    logic cur_or;
    logic volt_or;
    logic alarm_block;
    logic pulsed_low;
    logic wake;
    logic controlled;
    logic charge_enable;
    logic current_reduce;
    logic voltage_reduce;
  } status_t;
  // ==========================================================
  // Truncate a value down to a power-of-two step
  function automatic logic [15:0] trunc_step(input logic [15:0] v,
                                             input logic [3:0]  sh);
    trunc_step = (v >> sh) << sh;
  endfunction
endpackage

// ==== hw/bit_sync.sv ====
// Two flip-flop synchroniser for a group of slow levels.
// Assumes each bit is a level held far longer than two clocks.
`timescale 1ns/100ps
module bit_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] held;
  } sync_t;
  sync_t s;
  sync_t next_s;

  // ==========================================================
  // First stage feeds only the second
  always_comb begin
    next_s.meta = d;
    next_s.held = s.meta;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q = s.held;
endmodule

// ==== hw/value_limiter.sv ====
// Clamps, truncates and range-checks the requested setpoints.
// Assumes settings are already synchronised; purely combinational.
`timescale 1ns/100ps
module value_limiter (
  input  wire logic [15:0] cur_req,
  input  wire logic [15:0] volt_req,
  input  wire logic [1:0]  ilim_sel,
  input  wire logic [2:0]  vlim_sel,
  output logic      [15:0] cur_lim,
  output logic      [15:0] volt_lim,
  output logic             cur_over,
  output logic             volt_over,
  output logic             low_band
);
  import charger_pkg::*;
  logic [15:0] vmax;
  logic [15:0] vreq;
  logic [15:0] sixteenth;

  // ==========================================================
  // Hardware ceiling cannot be overridden by software
  always_comb begin
    vmax      = (vlim_sel > 3'd4) ? VOLT_MAX[4] : VOLT_MAX[vlim_sel];
    cur_over  = cur_req > CUR_MAX[ilim_sel];
    cur_lim   = trunc_step(cur_over ? CUR_MAX[ilim_sel] : cur_req,
                           CUR_SHIFT[ilim_sel]);
    vreq      = (volt_req <= VOLT_ZERO_TOP) ? 16'h0000 : volt_req;
    volt_over = vreq > vmax;
    volt_lim  = trunc_step(volt_over ? vmax : vreq, VOLT_SHIFT);
    // Full scale is limit plus one, pulsed band below a sixteenth
    sixteenth = 16'(CUR_MAX[ilim_sel] + 16'h0001) >> 4;
    low_band  = (cur_lim != 16'h0000) && (cur_lim < sixteenth);
  end
endmodule

// ==== dv/charger_chk.sv ====
// Output checker of the charger command logic.
// Assumes a bind to smbus_charger; system clock domain only.
`timescale 1ns/100ps
module charger_chk (
  input wire logic                   clock,
  input wire logic                   rst_n,
  input wire logic                   flag_a,
  input wire logic                   battery_over_voltage,
  input wire logic                   battery_over_current,
  input wire logic                   alert_oe_n,
  input wire charger_pkg::setpoint_t setpoint,
  input wire charger_pkg::status_t   status
);
  import charger_pkg::*;
  // ==========================================
  // Setpoint, mode and alert relations
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  cur_cap_a: assert property (setpoint.current <= 16'h0FFF)
    else $error("current above top limit");
  volt_cap_a: assert property (setpoint.voltage <= 16'h6D5F)
    else $error("voltage above top limit");
  volt_step_a: assert property (setpoint.voltage[3:0] == 4'h0)
    else $error("voltage off dac step");
  volt_zero_a: assert property (setpoint.voltage == 16'h0000 ||
    setpoint.voltage > 16'h049F) else $error("low voltage not zero");
  cur_reduce_a: assert property ((status.charge_enable &&
    battery_over_voltage) [*6] |-> status.current_reduce)
    else $error("current not reduced");
  volt_reduce_a: assert property ((status.charge_enable &&
    battery_over_current) [*6] |-> status.voltage_reduce)
    else $error("voltage not reduced");
  alarm_stop_a: assert property (status.alarm_block [*3]
    |-> !status.charge_enable) else $error("charging under alarm");
  adapter_alert_a: assert property ($changed(flag_a)
    |-> ##[1:6] !alert_oe_n) else $error("no alert on adapter");
  pulse_band_a: assert property (status.pulsed_low |->
    setpoint.current != 16'h0000 && setpoint.current < 16'h0100)
    else $error("pulsed mode out of band");
  mode_excl_a: assert property (!(status.wake &&
    status.controlled)) else $error("wake and controlled together");
  cover property (status.wake);
  cover property (status.controlled);
  cover property (status.alarm_block);
  cover property (status.pulsed_low);
endmodule
bind smbus_charger charger_chk u_chk (.clock(clock), .rst_n(rst_n),
  .flag_a(flag_a), .battery_over_voltage(battery_over_voltage),
  .battery_over_current(battery_over_current),
  .alert_oe_n(alert_oe_n), .setpoint(setpoint), .status(status));

// ==== dv/smbus_master.sv ====
// Bus master model standing for the battery and the host.
// Assumes the bench resolves the open-drain wire with a pull-up.
`timescale 1ns/100ps
module smbus_master (
  input  wire logic link_clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  logic nack;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    nack = 1'b0;
  end
  // ==========================================
  // Bit level; clock stands still between frames
  task automatic ph(input logic c, input logic l);
    repeat (8) @(negedge link_clk);
    scl = c;
    sda_low = l;
  endtask
  task automatic start();
    ph(scl, 1'b0);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
    ph(1'b0, 1'b1);
  endtask
  task automatic stop();
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
    ph(1'b1, 1'b0);
  endtask
  // Data held across the fall, sampled mid high
  task automatic bit_io(input logic b, output logic r);
    ph(1'b0, !b);
    ph(1'b1, !b);
    repeat (8) @(negedge link_clk);
    r = sda;
    ph(1'b0, !b);
  endtask
  task automatic byte_io(input logic [7:0] d, input logic m,
                         output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(m, a);
  endtask
  task automatic wr(input logic [7:0] d);
    logic [7:0] q;
    logic       a;
    byte_io(d, 1'b1, q, a);
    nack = nack | a;
  endtask
  // ==========================================
  // Transfers, low byte first
  task automatic write_word(input logic [7:0] c, input logic [15:0] v);
    start();
    wr(8'h12);
    wr(c);
    wr(v[7:0]);
    wr(v[15:8]);
    stop();
  endtask
  task automatic read_word(input logic [7:0] c, output logic [15:0] v);
    logic a;
    start();
    wr(8'h12);
    wr(c);
    start();
    wr(8'h13);
    byte_io(8'hFF, 1'b0, v[7:0], a);
    byte_io(8'hFF, 1'b1, v[15:8], a);
    stop();
  endtask
  // Released wire reads ones when nobody answers
  task automatic ara(output logic [7:0] v);
    logic a;
    start();
    byte_io(8'h19, 1'b1, v, a);
    byte_io(8'hFF, 1'b1, v, a);
    stop();
  endtask
endmodule

// ==== dv/smbus_charger_tb_top.sv ====
// Self-checking bench of the smart charger command logic.
// Assumes the master model and the bound checker compile first.
`timescale 1ns/100ps
module smbus_charger_tb_top;
  import charger_pkg::*;
  `define CHK(nm, ex, gt) begin check_count++; \
    if ((gt) !== (ex)) begin n_errors++; \
      $display("MISMATCH %s exp %0h got %0h", nm, ex, gt); end end
  localparam logic [11:0] VID = 12'h3C5; // Value is arbitrary
  logic        clock, link_clk, rst_n, flag_a, present, bov, boc;
  logic        scl, sda_low, sda_in, sda_out, sda_oe_n, alert_oe_n;
  logic        alert_out;
  safety_t     safety;
  logic [1:0]  ilim;
  logic [2:0]  vlim;
  setpoint_t   sp;
  status_t     st;
  logic [15:0] w;
  logic [7:0]  b;
  int          n_errors = 0;
  int          check_count = 0;
  // ==========================================
  // Clocks, wire, design and master
  always #25 clock = ~clock;
  always #16 link_clk = ~link_clk;
  assign sda_in = !sda_low && (sda_oe_n || sda_out);
  smbus_charger #(.TIMEOUT_MS(1), .VERSION_ID(VID)) DUT (
    .clock(clock), .rst_n(rst_n), .clock_enable(1'b1),
    .link_clk(link_clk), .scl(scl), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .alert_in(alert_oe_n),
    .alert_out(alert_out), .alert_oe_n(alert_oe_n), .flag_a(flag_a),
    .battery_present_flag(present), .safety(safety),
    .current_limit_resistor(ilim), .voltage_limit_resistor(vlim),
    .battery_over_voltage(bov), .battery_over_current(boc),
    .setpoint(sp), .status(st));
  smbus_master bus (.link_clk(link_clk), .sda(sda_in), .scl(scl),
    .sda_low(sda_low));
  // Pin changes land within four edges
  task automatic settle();
    repeat (8) @(negedge clock);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_alert();
    `CHK("por alert", 1'b0, alert_oe_n)
    `CHK("alert pin", 1'b0, alert_out)
    bus.ara(b);
    `CHK("ara addr", 8'h12, b)
    settle();
    `CHK("alert off", 1'b1, alert_oe_n)
    bus.ara(b);
    `CHK("ara idle", 8'hFF, b)
    @(negedge clock);
    flag_a = 1'b0;
    settle();
    `CHK("adapter alert", 1'b0, alert_oe_n)
    flag_a = 1'b1;
    bus.ara(b);
  endtask
  task automatic t_wake();
    @(negedge clock);
    present = 1'b1;
    settle();
    `CHK("wake on", 1'b1, st.wake)
    safety = 5'b00001;
    settle();
    `CHK("wake hot", 1'b0, st.wake)
    // Reinsert on a cold line; wake must end at the timeout
    present = 1'b0;
    safety = 5'b10000;
    settle();
    present = 1'b1;
    repeat (19990) @(negedge clock);
    `CHK("wake cold", 1'b1, st.wake)
    repeat (3) settle();
    `CHK("wake timeout", 1'b0, st.wake)
    safety = 5'b01000;
    bus.ara(b);
  endtask
  task automatic t_limits();
    @(negedge clock);
    ilim = 2'd2;
    bus.write_word(CMD_VOLTAGE, 16'h049F);
    bus.write_word(CMD_CURRENT, 16'h0FFF);
    settle();
    `CHK("low volt", 16'h0000, sp.voltage)
    `CHK("cur over", 1'b1, st.cur_or)
    bus.write_word(CMD_VOLTAGE, 16'h1234);
    settle();
    `CHK("controlled", 1'b1, st.controlled)
    `CHK("cur clamp", 16'h0BFC, sp.current)
    `CHK("volt step", 16'h1230, sp.voltage)
    bov = 1'b1;
    boc = 1'b1;
    settle();
    `CHK("cur cut", 1'b1, st.current_reduce)
    `CHK("volt cut", 1'b1, st.voltage_reduce)
    bov = 1'b0;
    boc = 1'b0;
    bus.write_word(CMD_VOLTAGE, 16'h6D60);
    settle();
    `CHK("volt over", 1'b1, st.volt_or)
    `CHK("volt clamp", 16'h6D50, sp.voltage)
  endtask
  task automatic t_alarm();
    bus.write_word(CMD_ALARM, 16'h0B0F);
    settle();
    `CHK("alarm ignored", 1'b0, st.alarm_block)
    for (int i = 12; i < 16; i++) begin
      bus.write_word(CMD_ALARM, 16'h0001 << i);
      settle();
      `CHK("alarm block", 1'b1, st.alarm_block)
      `CHK("inhibit", 1'b0, st.charge_enable)
      `CHK("alarm alert", 1'b0, alert_oe_n)
      bus.ara(b);
      bus.write_word(CMD_VOLTAGE, 16'h1234);
      bus.write_word(CMD_CURRENT, 16'h0010);
      settle();
      `CHK("block clear", 1'b0, st.alarm_block)
    end
    `CHK("pulsed", 1'b1, st.pulsed_low)
  endtask
  task automatic t_vendor();
    bus.read_word(CMD_VENDOR, w);
    `CHK("vendor rd", {4'h0, VID}, w)
    bus.write_word(CMD_VENDOR, 16'hFFFF);
    bus.read_word(CMD_VENDOR, w);
    `CHK("vendor pmd", {4'h1, VID}, w)
    settle();
    `CHK("pulse off", 1'b0, st.pulsed_low)
    bus.read_word(CMD_CURRENT, w);
    `CHK("wo read", 16'hFFFF, w)
    `CHK("wo keep", 16'h0010, sp.current)
    `CHK("bus acks", 1'b0, bus.nack)
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ==========================================
  // Main sequence and hang limit
  initial begin
    clock = 1'b0;
    link_clk = 1'b0;
    rst_n = 1'b0;
    flag_a = 1'b1;
    present = 1'b0;
    bov = 1'b0;
    boc = 1'b0;
    safety = 5'b01000;
    ilim = 2'd3;
    vlim = 3'd4;
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    settle();
    t_alert();
    t_wake();
    t_limits();
    t_alarm();
    t_vendor();
    end_of_test();
  end
  initial begin
    repeat (100000) @(posedge clock);
    n_errors++;
    end_of_test();
  end
endmodule
